// ### sere_pkg.sv
// Shared constants and types of the serial EEPROM read engine
package sere_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int            CORE_PERIOD_NS = 10;
	localparam int            SCL_PERIOD_NS  = 160;
	localparam logic [7:0]    QUARTER_CYCLES =
		8'(SCL_PERIOD_NS / (4 * CORE_PERIOD_NS));
	// ------------------------------------------------------------
	// Link framing and addressing
	// ------------------------------------------------------------
	localparam logic [3:0]    BYTE_BITS       = 4'h8;
	localparam logic [3:0]    LINK_BITS       = 4'h9;
	localparam int            MEM_ADDR_W      = 11;
	localparam int            PAGE_W          = 3;
	localparam int            PAGE_LOW_W      = 4;
	localparam int            SPEC_IDX_W      = 4;
	localparam logic [3:0]    DEV_CODE_MAIN   = 4'hA;
	localparam logic [3:0]    DEV_CODE_SPEC   = 4'hB;
	localparam int            WA_SEL_HI       = 7;
	localparam int            WA_SEL_LO       = 6;
	localparam int            WA_LOCK_BIT     = 6;
	localparam logic [1:0]    SEL_SERIAL      = 2'h2;
	localparam logic [1:0]    SEL_SECTOR      = 2'h0;
	localparam int            LOCK_FLAG_POSITION = 1;
	typedef enum logic [1:0] {
		REG_MAIN,
		REG_SERIAL,
		REG_SECTOR,
		REG_LOCK
	} sere_region_e;
	// ------------------------------------------------------------
	// Controller registers
	// ------------------------------------------------------------
	localparam int            AXI_ADDR_W  = 4;
	localparam logic [3:0]    OFS_CMD     = 4'h0;
	localparam logic [3:0]    OFS_STATUS  = 4'h4;
	localparam logic [3:0]    OFS_DIV     = 4'h8;
	localparam int            CMD_TX_LO   = 0;
	localparam int            CMD_START   = 8;
	localparam int            CMD_WRITE   = 9;
	localparam int            CMD_READ    = 10;
	localparam int            CMD_NACK    = 11;
	localparam int            CMD_STOP    = 12;
	localparam int            STAT_BUSY   = 0;
	localparam int            STAT_NACK   = 1;
	localparam int            STAT_RX_LO  = 8;
	localparam logic [7:0]    DIV_RESET   = QUARTER_CYCLES;
	localparam logic [1:0]    AXI_OKAY    = 2'h0;
	localparam logic [1:0]    AXI_SLVERR  = 2'h2;
endpackage : sere_pkg

// ### sere_if.sv
// Two-wire link between controller and EEPROM engine
`timescale 1ns/10ps
interface sere_if;
	logic scl;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic sda;

	// Open-drain data line with pull-up
	assign sda = ~(sda_host_oe | sda_dev_oe);

	modport dev  (input scl, input sda, output sda_dev_oe);
	modport host (output scl, output sda_host_oe, input sda);
endinterface : sere_if

// ### sere_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sere_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic         core_ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta <= '1;
			q    <= '1;
		end
		else if (core_ce)
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : sere_sync

// ### sere_dev.sv
// EEPROM end: two-wire target read engine
//
// Function
// - Locked sector: lock command data not acknowledged
// - Read starts like write, direction bit one
// - Address counter holds last address plus one
// - Read wraps whole array, write wraps page
// - Current read outputs byte at counter
// - Dummy write loads address, then read
// - Acknowledged byte advances address, streams on
// - Controller ends stream with no-ack, stop
// - Word address 10b selects serial index
// - Serial number index wraps after sixteen bytes
// - Word address 00b selects sector index
// - Sector read index wraps 0Fh to 00h
// - Sector write acknowledged only when unlocked
// - Controller follows probe with start, stop
// - Start discards command, stop gives standby
// - Word address bit 6 selects lock status
// - Lock flag at bit one of status
// - Lock status byte repeats every byte
// - Main access code 1010, page, direction
// - Special access code 1011
// - Eight-bit bytes, ninth clock acknowledge
`timescale 1ns/10ps
module sere_dev (
	input  wire logic                               core_clk,
	input  wire logic                               resetn,
	input  wire logic                               core_ce,
	sere_if.dev                                     bus,
	input  wire logic                               sector_locked,
	output sere_pkg::sere_region_e                  rd_region,
	output logic [sere_pkg::MEM_ADDR_W-1:0]         rd_index,
	input  wire logic [7:0]                         rd_data,
	output logic                                    engine_busy
);
	// ------------------------------------------------------------
	// Types and decoders
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		D_IDLE,
		D_DEVADDR,
		D_WADDR,
		D_WDATA,
		D_ACK,
		D_SEND,
		D_HACK,
		D_IGNORE
	} sere_dev_state_e;

	function automatic sere_pkg::sere_region_e wa_region(
		input logic [7:0] wa
	);
		if (wa[sere_pkg::WA_LOCK_BIT])
			return sere_pkg::REG_LOCK;
		else if (wa[sere_pkg::WA_SEL_HI:sere_pkg::WA_SEL_LO] ==
			sere_pkg::SEL_SERIAL)
			return sere_pkg::REG_SERIAL;
		else if (wa[sere_pkg::WA_SEL_HI:sere_pkg::WA_SEL_LO] ==
			sere_pkg::SEL_SECTOR)
			return sere_pkg::REG_SECTOR;
		else
			return sere_pkg::REG_SECTOR;
	endfunction : wa_region

	function automatic logic data_ack(
		input sere_pkg::sere_region_e rg,
		input logic                   locked
	);
		case (rg)
			sere_pkg::REG_MAIN:   return 1'b1;
			sere_pkg::REG_SECTOR: return ~locked;
			sere_pkg::REG_LOCK:   return ~locked;
			default:              return 1'b0;
		endcase
	endfunction : data_ack

	// ------------------------------------------------------------
	// Pin sampling and bus conditions
	// ------------------------------------------------------------
	logic [1:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_p;
	logic       sda_p;
	logic       start_c;
	logic       stop_c;
	logic       scl_rise;
	logic       scl_fall;

	sere_sync #(
		.W        (2)
	) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.core_ce  (core_ce),
		.d        ({bus.scl, bus.sda}),
		.q        (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end
		else if (core_ce)
		begin
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end

	assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;

	// ------------------------------------------------------------
	// Byte decisions
	// ------------------------------------------------------------
	sere_dev_state_e                state;
	sere_dev_state_e                after_ack;
	sere_dev_state_e                rx_next;
	sere_pkg::sere_region_e         acc_region;
	sere_pkg::sere_region_e         spec_sel;
	sere_pkg::sere_region_e         rx_region;
	logic [3:0]                     bit_cnt;
	logic [7:0]                     shreg;
	logic [7:0]                     out_byte;
	logic [7:0]                     lock_byte;
	logic [sere_pkg::PAGE_W-1:0]    page_hold;
	logic [sere_pkg::MEM_ADDR_W-1:0] main_addr;
	logic [sere_pkg::SPEC_IDX_W-1:0] spec_idx;
	logic                           sda_drv;
	logic                           host_acked;
	logic                           rx_ack;
	logic                           receiving;
	logic                           byte_done;
	logic                           load_now;

	assign receiving = (state == D_DEVADDR) || (state == D_WADDR) ||
		(state == D_WDATA);
	assign byte_done = receiving && scl_fall &&
		(bit_cnt == sere_pkg::BYTE_BITS);
	assign load_now = scl_fall &&
		(((state == D_ACK) && (after_ack == D_SEND)) ||
		((state == D_HACK) && host_acked));

	always_comb
	begin
		rx_ack    = 1'b0;
		rx_next   = D_IGNORE;
		rx_region = acc_region;
		case (state)
			D_DEVADDR:
			begin
				if (shreg[7:4] == sere_pkg::DEV_CODE_MAIN)
				begin
					rx_ack    = 1'b1;
					rx_region = sere_pkg::REG_MAIN;
				end
				else if (shreg[7:4] == sere_pkg::DEV_CODE_SPEC)
				begin
					rx_ack    = 1'b1;
					rx_region = spec_sel;
				end
				if (rx_ack)
					rx_next = shreg[0] ? D_SEND : D_WADDR;
			end
			D_WADDR:
			begin
				rx_ack  = 1'b1;
				rx_next = D_WDATA;
				if (acc_region != sere_pkg::REG_MAIN)
					rx_region = wa_region(shreg);
			end
			D_WDATA:
			begin
				rx_ack  = data_ack(acc_region, sector_locked);
				rx_next = rx_ack ? D_WDATA : D_IGNORE;
			end
			default:
			begin
				rx_ack = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		lock_byte = 8'h00;
		lock_byte[sere_pkg::LOCK_FLAG_POSITION] = sector_locked;
	end

	assign out_byte = (acc_region == sere_pkg::REG_LOCK) ?
		lock_byte : rd_data;

	// ------------------------------------------------------------
	// Link state machine
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state      <= D_IDLE;
			after_ack  <= D_IDLE;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			sda_drv    <= 1'b0;
			host_acked <= 1'b0;
			acc_region <= sere_pkg::REG_MAIN;
			page_hold  <= '0;
		end
		else if (core_ce)
		begin
			if (start_c)
			begin
				state   <= D_DEVADDR;
				bit_cnt <= 4'h0;
				sda_drv <= 1'b0;
			end
			else if (stop_c)
			begin
				state   <= D_IDLE;
				sda_drv <= 1'b0;
			end
			else if (load_now)
			begin
				shreg   <= {out_byte[6:0], 1'b1};
				sda_drv <= ~out_byte[7];
				bit_cnt <= 4'h1;
				state   <= D_SEND;
			end
			else
			begin
				case (state)
					D_DEVADDR, D_WADDR, D_WDATA:
					begin
						if (scl_rise && (bit_cnt != sere_pkg::BYTE_BITS))
						begin
							shreg   <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end
						else if (byte_done)
						begin
							bit_cnt    <= 4'h0;
							sda_drv    <= rx_ack;
							after_ack  <= rx_next;
							acc_region <= rx_region;
							state      <= D_ACK;
							if (state == D_DEVADDR)
								page_hold <= shreg[3:1];
						end
					end
					D_ACK:
					begin
						if (scl_fall)
						begin
							sda_drv <= 1'b0;
							state   <= after_ack;
						end
					end
					D_SEND:
					begin
						if (scl_fall && (bit_cnt == sere_pkg::BYTE_BITS))
						begin
							sda_drv    <= 1'b0;
							host_acked <= 1'b0;
							state      <= D_HACK;
						end
						else if (scl_fall)
						begin
							sda_drv <= ~shreg[7];
							shreg   <= {shreg[6:0], 1'b1};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
					D_HACK:
					begin
						if (scl_rise)
							host_acked <= ~sda_s;
						else if (scl_fall)
							state <= D_IGNORE;
					end
					default:
					begin
						sda_drv <= 1'b0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Address counters
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			main_addr <= '0;
			spec_idx  <= '0;
			spec_sel  <= sere_pkg::REG_SECTOR;
		end
		else if (core_ce)
		begin
			if (byte_done && (state == D_WADDR))
			begin
				if (acc_region == sere_pkg::REG_MAIN)
					main_addr <= {page_hold, shreg};
				else
				begin
					spec_sel <= wa_region(shreg);
					spec_idx <= shreg[3:0];
				end
			end
			else if (byte_done && (state == D_WDATA) && rx_ack)
			begin
				if (acc_region == sere_pkg::REG_MAIN)
					main_addr <= {main_addr[sere_pkg::MEM_ADDR_W-1:
						sere_pkg::PAGE_LOW_W],
						main_addr[sere_pkg::PAGE_LOW_W-1:0] + 4'h1};
				else if (acc_region == sere_pkg::REG_SECTOR)
					spec_idx <= spec_idx + 4'h1;
			end
			else if (load_now)
			begin
				case (acc_region)
					sere_pkg::REG_MAIN:
						main_addr <= main_addr + 11'h001;
					sere_pkg::REG_SERIAL:
						spec_idx <= spec_idx + 4'h1;
					sere_pkg::REG_SECTOR:
						spec_idx <= spec_idx + 4'h1;
					default:
						spec_idx <= spec_idx;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign bus.sda_dev_oe = sda_drv;
	assign rd_region      = acc_region;
	assign rd_index       = (acc_region == sere_pkg::REG_MAIN) ? main_addr :
		{7'h00, spec_idx};
	assign engine_busy    = (state != D_IDLE) && (state != D_IGNORE);
endmodule : sere_dev

// ### sere_host.sv
// Controller end: byte-level two-wire master behind AXI4-Lite
`timescale 1ns/10ps
module sere_host (
	input  wire logic                          core_clk,
	input  wire logic                          resetn,
	input  wire logic                          core_ce,
	sere_if.host                               bus,
	input  wire logic [sere_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [sere_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);
	typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_TAIL, H_STOP}
		sere_host_state_e;

	sere_host_state_e                 phase;
	logic [sere_pkg::AXI_ADDR_W-1:0]  aw_addr;
	logic [31:0]                      w_data;
	logic [3:0]                       w_strb;
	logic                             aw_held;
	logic                             w_held;
	logic                             wr_do;
	logic                             cmd_go;
	logic [7:0]                       div;
	logic [7:0]                       timer;
	logic [1:0]                       qtr;
	logic [3:0]                       bit_cnt;
	logic [8:0]                       tx9;
	logic [8:0]                       rx9;
	logic [7:0]                       rx_byte;
	logic                             nack_seen;
	logic                             pend_byte;
	logic                             pend_stop;
	logic                             tick;
	logic                             sda_s;
	logic                             busy;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	assign busy          = (phase != H_IDLE);
	assign s_axi_awready = core_ce & ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = core_ce & ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = core_ce & ~s_axi_rvalid;
	assign wr_do         = aw_held & w_held & ~s_axi_bvalid;
	assign cmd_go        = wr_do & (aw_addr == sere_pkg::OFS_CMD) & ~busy;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= '0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= sere_pkg::AXI_OKAY;
			div          <= sere_pkg::DIV_RESET;
		end
		else if (core_ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_do)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == sere_pkg::OFS_CMD ||
					aw_addr == sere_pkg::OFS_STATUS ||
					aw_addr == sere_pkg::OFS_DIV) ?
					sere_pkg::AXI_OKAY : sere_pkg::AXI_SLVERR;
				if (aw_addr == sere_pkg::OFS_DIV && w_strb[0])
					div <= w_data[7:0];
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= sere_pkg::AXI_OKAY;
		end
		else if (core_ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= sere_pkg::AXI_OKAY;
				case (s_axi_araddr)
					sere_pkg::OFS_CMD:    s_axi_rdata <= 32'h00000000;
					sere_pkg::OFS_STATUS: s_axi_rdata <= {16'h0000, rx_byte,
						6'h00, nack_seen, busy};
					sere_pkg::OFS_DIV:    s_axi_rdata <= {24'h000000, div};
					default:
					begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= sere_pkg::AXI_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Bit engine
	// ------------------------------------------------------------
	sere_sync #(
		.W        (1)
	) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.core_ce  (core_ce),
		.d        (bus.sda),
		.q        (sda_s)
	);

	assign tick = busy && (timer == 8'h00);

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			phase           <= H_IDLE;
			timer           <= 8'h00;
			qtr             <= 2'h0;
			bit_cnt         <= 4'h0;
			tx9             <= 9'h1FF;
			rx9             <= 9'h000;
			rx_byte         <= 8'h00;
			nack_seen       <= 1'b0;
			pend_byte       <= 1'b0;
			pend_stop       <= 1'b0;
			bus.scl         <= 1'b1;
			bus.sda_host_oe <= 1'b0;
		end
		else if (core_ce)
		begin
			if (cmd_go)
			begin
				pend_byte <= w_data[sere_pkg::CMD_WRITE] |
					w_data[sere_pkg::CMD_READ];
				pend_stop <= w_data[sere_pkg::CMD_STOP];
				tx9 <= w_data[sere_pkg::CMD_WRITE] ?
					{w_data[sere_pkg::CMD_TX_LO +: 8], 1'b1} :
					{8'hFF, w_data[sere_pkg::CMD_NACK]};
				timer   <= div;
				qtr     <= 2'h0;
				bit_cnt <= 4'h0;
				if (w_data[sere_pkg::CMD_START])
					phase <= H_START;
				else if (w_data[sere_pkg::CMD_WRITE] | w_data[sere_pkg::CMD_READ])
					phase <= H_BYTE;
				else if (w_data[sere_pkg::CMD_STOP])
					phase <= H_STOP;
			end
			else if (busy && !tick)
				timer <= timer - 8'h01;
			else if (tick)
			begin
				timer <= div;
				qtr   <= qtr + 2'h1;
				case (phase)
					H_START:
					begin
						case (qtr)
							2'h0: bus.scl <= 1'b0;
							2'h1: bus.sda_host_oe <= 1'b0;
							2'h2: bus.scl <= 1'b1;
							default:
							begin
								bus.sda_host_oe <= 1'b1;
								phase <= pend_byte ? H_BYTE :
									(pend_stop ? H_STOP : H_IDLE);
							end
						endcase
					end
					H_BYTE:
					begin
						case (qtr)
							2'h0: bus.scl <= 1'b0;
							2'h1: bus.sda_host_oe <= ~tx9[8];
							2'h2: bus.scl <= 1'b1;
							default:
							begin
								rx9     <= {rx9[7:0], sda_s};
								tx9     <= {tx9[7:0], 1'b1};
								bit_cnt <= bit_cnt + 4'h1;
								if (bit_cnt == sere_pkg::BYTE_BITS)
								begin
									rx_byte   <= rx9[7:0];
									nack_seen <= sda_s;
									phase <= pend_stop ? H_STOP : H_TAIL;
								end
							end
						endcase
					end
					H_TAIL:
					begin
						bus.scl <= 1'b0;
						phase   <= H_IDLE;
					end
					H_STOP:
					begin
						case (qtr)
							2'h0: bus.scl <= 1'b0;
							2'h1: bus.sda_host_oe <= 1'b1;
							2'h2: bus.scl <= 1'b1;
							default:
							begin
								bus.sda_host_oe <= 1'b0;
								phase <= H_IDLE;
							end
						endcase
					end
					default:
					begin
						phase <= H_IDLE;
					end
				endcase
			end
		end
	end
endmodule : sere_host

// ### sere_props.sv
// Assertions on the two-wire link
`timescale 1ns/10ps
module sere_props (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda_dev_oe,
	input wire logic sda
);
	logic       scl_q, sda_q, first, rd_q;
	logic [3:0] cnt;
	logic [7:0] sh;
	wire logic  rise  = scl & ~scl_q;
	wire logic  hi    = scl & scl_q;
	wire logic  start = hi & sda_q & ~sda;
	wire logic  stop  = hi & ~sda_q & sda;
	wire logic  ack_e = rise & (cnt == 4'h8) & first;
	wire logic  ok    = sh[7:5] == 3'h5;
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			{scl_q, sda_q, first, rd_q, cnt, sh} <= 16'hC000;
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			if (start)
				{first, rd_q, cnt} <= 6'h20;
			else if (rise)
			begin
				cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
				first <= first & (cnt != 4'h9);
				sh <= (cnt < 4'h8) ? {sh[6:0], sda} : sh;
				rd_q <= ack_e ? (sh[0] & ok) : rd_q;
			end
		end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	AST_EDGE_LOW:
		assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("sda moved, scl high");
	AST_RESET_IDLE:
		assert property ($rose(resetn) |-> scl && !sda_dev_oe)
		else $error("not idle");
	AST_ADDR_QUIET:
		assert property (first && hi && cnt inside {[1:8]} |-> !sda_dev_oe)
		else $error("drove address bit");
	AST_START_FREE:
		assert property (start |=> !sda_dev_oe [*4])
		else $error("drove after start");
	AST_STOP_FREE:
		assert property (stop |=> !sda_dev_oe [*8])
		else $error("drove after stop");
	AST_ACK_CODE:
		assert property (ack_e && ok |-> !sda)
		else $error("code not acked");
	AST_NACK_CODE:
		assert property (ack_e && !ok |-> sda)
		else $error("bad code acked");
	AST_HOST_SLOT:
		assert property (rd_q && !first && hi && cnt == 4'h9 |-> !sda_dev_oe)
		else $error("drove host ack");
endmodule : sere_props

// ### test_serial_eeprom_read_engine.sv
// Bench: controller over AXI4-Lite against the engine
`timescale 1ns/10ps
module test_serial_eeprom_read_engine;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        sector_locked = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, st;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rr;
	logic [7:0]  rd_data;
	logic        eng_busy;
	logic [10:0] rd_index;
	sere_pkg::sere_region_e rd_region;
	int          n_fail = 0, comparisons = 0, cyc = 0;
	sere_if      link ();
	assign rd_data = {rd_region, 6'h0} ^ rd_index[7:0] ^ {5'h0, rd_index[10:8]};
	sere_dev i_sere_dev (.core_clk(core_clk), .resetn(resetn), .core_ce(1'b1),
		.bus(link.dev), .sector_locked(sector_locked), .rd_region(rd_region),
		.rd_index(rd_index), .rd_data(rd_data), .engine_busy(eng_busy));
	sere_host i_sere_host (.core_clk(core_clk), .resetn(resetn), .core_ce(1'b1),
		.bus(link.host), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	sere_props i_sere_props (.core_clk(core_clk), .resetn(resetn),
		.scl(link.scl), .sda_dev_oe(link.sda_dev_oe), .sda(link.sda));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aok, wok;
		{aok, wok} = 2'b00;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aok && wok))
		begin
			@(negedge core_clk);
			aok = aok | (awready === 1'b1);
			wok = wok | (wready === 1'b1);
			@(posedge core_clk);
			awvalid <= awvalid & ~aok;
			wvalid <= wvalid & ~wok;
		end
		do @(negedge core_clk); while (bvalid !== 1'b1);
		@(posedge core_clk);
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge core_clk); while (arready !== 1'b1);
		@(posedge core_clk);
		arvalid <= 1'b0;
		do @(negedge core_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge core_clk);
		rready <= 1'b0;
	endtask : axi_rd
	task automatic op(input logic [4:0] f, input logic [7:0] b);
		axi_wr(sere_pkg::OFS_CMD, {19'h0, f, b});
		do axi_rd(sere_pkg::OFS_STATUS, st, rr);
		while (st[sere_pkg::STAT_BUSY] !== 1'b0);
	endtask : op
	task automatic wr(input logic [7:0] b, input logic [2:0] m);
		op({m[1], 3'b001, m[2]}, b);
		chk("ack", {7'h0, m[0]}, {7'h0, st[sere_pkg::STAT_NACK]});
	endtask : wr
	task automatic rd(input logic n, input logic [7:0] e);
		op({n, n, 3'b100}, 8'h00);
		chk("data", e, st[15:8]);
	endtask : rd
	task automatic sel(input logic [7:0] dv, input logic [7:0] wa);
		wr(dv, 3'b100);
		wr(wa, 3'b000);
		wr(dv | 8'h01, 3'b100);
	endtask : sel
	task automatic probe(input logic [7:0] wa, input logic lk);
		wr(8'hB0, 3'b100);
		wr(wa, 3'b000);
		wr(8'h5A, {2'b00, lk});
		op(5'b10001, 8'h00);
	endtask : probe
	initial
	begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		sel(8'hAE, 8'hFE);
		chk("busy", 8'h01, {7'h0, eng_busy});
		rd(1'b0, 8'hF9);
		rd(1'b0, 8'hF8);
		rd(1'b1, 8'h00);
		wr(8'hA1, 3'b100);
		rd(1'b1, 8'h01);
		sel(8'hB0, 8'hBE);
		rd(1'b0, 8'h4E);
		rd(1'b0, 8'h4F);
		rd(1'b1, 8'h40);
		sel(8'hB0, 8'h3F);
		rd(1'b0, 8'h8F);
		rd(1'b1, 8'h80);
		for (int k = 0; k < 2; k++)
		begin
			sector_locked <= k[0];
			sel(8'hB0, {k[0], 7'h40});
			op(5'b00100, 8'h00);
			chk("lock", {6'h0, k[0], 1'b0}, st[15:8]);
			rd(1'b1, {6'h0, k[0], 1'b0});
			probe(8'h05, k[0]);
			probe(8'h40, k[0]);
		end
		wr(8'h50, 3'b111);
		chk("idle", 8'h00, {7'h0, eng_busy});
		axi_rd(4'hC, st, rr);
		chk("resp", {6'h0, sere_pkg::AXI_SLVERR}, {6'h0, rr});
		report_and_stop();
	end
endmodule : test_serial_eeprom_read_engine
